//--- design/pecc_pkg.sv
`default_nettype none

package pecc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned REG_W   = 16;
  localparam int unsigned BE_W    = 4;
  localparam int unsigned RATIO_W = 11;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_LINE_OUT   = 6'h0F;
  localparam logic [5:0] IDX_SPK_MIXER  = 6'h10;
  localparam logic [5:0] IDX_SPK_OUTPUT = 6'h11;
  localparam logic [5:0] IDX_CONVERTER  = 6'h12;
  localparam logic [5:0] IDX_MCLK_DIV   = 6'h14;
  localparam logic [5:0] IDX_SYS_RATE   = 6'h15;

  localparam logic [ADDR_W-1:0] ADDR_LINE_OUT   = {IDX_LINE_OUT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SPK_MIXER  = {IDX_SPK_MIXER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SPK_OUTPUT = {IDX_SPK_OUTPUT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CONVERTER  = {IDX_CONVERTER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MCLK_DIV   = {IDX_MCLK_DIV, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SYS_RATE   = {IDX_SYS_RATE, 2'h0};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned LEFT_BIT      = 1;
  localparam int unsigned RIGHT_BIT     = 0;
  localparam int unsigned DAC_LEFT_BIT  = 3;
  localparam int unsigned DAC_RIGHT_BIT = 2;
  localparam int unsigned ADC_LEFT_BIT  = 1;
  localparam int unsigned ADC_RIGHT_BIT = 0;
  localparam int unsigned HALVE_BIT     = 0;
  localparam int unsigned SOURCE_BIT    = 15;
  localparam int unsigned RATIO_MSB     = 13;
  localparam int unsigned RATIO_LSB     = 10;
  localparam int unsigned FAMILY_MSB    = 9;
  localparam int unsigned FAMILY_LSB    = 8;

  // ----------------------------------------------------------------
  // Reset values and code limits
  // ----------------------------------------------------------------
  localparam logic       ENABLE_RESET       = 1'b0;
  localparam logic       SOURCE_RESET       = 1'b0;
  localparam logic       HALVE_RESET        = 1'b0;
  localparam logic [3:0] RATIO_RESET        = 4'h3;
  localparam logic [1:0] FAMILY_RESET       = 2'h0;
  localparam logic [3:0] RATIO_FIRST_RSVD   = 4'hA;

  typedef enum logic [1:0] {
    FAMILY_256      = 2'b00,
    FAMILY_272      = 2'b01,
    FAMILY_250      = 2'b10,
    FAMILY_RESERVED = 2'b11
  } pecc_family_type;

  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } pecc_bus_state_type;

  // ----------------------------------------------------------------
  // Ratio tables, multiples of the sample rate
  // ----------------------------------------------------------------
  localparam logic [RATIO_W-1:0] RATIO_256_TABLE [0:9] = '{
    11'h040, 11'h080, 11'h0C0, 11'h100, 11'h180,
    11'h200, 11'h300, 11'h400, 11'h580, 11'h600};
  localparam logic [RATIO_W-1:0] RATIO_272_TABLE [0:9] = '{
    11'h044, 11'h088, 11'h0CC, 11'h110, 11'h198,
    11'h220, 11'h330, 11'h440, 11'h5D8, 11'h660};
  localparam logic [RATIO_W-1:0] RATIO_250_TABLE [0:9] = '{
    11'h07D, 11'h07D, 11'h0FA, 11'h0FA, 11'h177,
    11'h1F4, 11'h2EE, 11'h3E8, 11'h3E8, 11'h5DC};

endpackage

`default_nettype wire

//--- design/pecc_ratio_if.sv
`timescale 1ns/1ns
`default_nettype none

interface pecc_ratio_if;
  logic [1:0]                  family;
  logic [3:0]                  code;
  logic [pecc_pkg::RATIO_W-1:0] multiple;
  logic                        valid;

  modport control (
    output family,
    output code,
    input  multiple,
    input  valid
  );

  modport decoder (
    input  family,
    input  code,
    output multiple,
    output valid
  );
endinterface

`default_nettype wire

//--- design/pecc_ratio_decode.sv
`timescale 1ns/1ns
`default_nettype none

module pecc_ratio_decode (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  pecc_ratio_if.decoder    ratio
);

  logic [pecc_pkg::RATIO_W-1:0] next_multiple;
  logic                         next_valid;
  logic [3:0]                   index;

  assign index = ratio.code;

  // ----------------------------------------------------------------
  // Code to multiple lookup
  // ----------------------------------------------------------------
  always_comb begin
    next_multiple = '0;
    next_valid    = 1'b0;
    if (index < pecc_pkg::RATIO_FIRST_RSVD) begin
      unique case (pecc_pkg::pecc_family_type'(ratio.family))
        pecc_pkg::FAMILY_256: begin
          next_multiple = pecc_pkg::RATIO_256_TABLE[index];
          next_valid    = 1'b1;
        end
        pecc_pkg::FAMILY_272: begin
          next_multiple = pecc_pkg::RATIO_272_TABLE[index];
          next_valid    = 1'b1;
        end
        pecc_pkg::FAMILY_250: begin
          next_multiple = pecc_pkg::RATIO_250_TABLE[index];
          next_valid    = 1'b1;
        end
        pecc_pkg::FAMILY_RESERVED: begin
          next_multiple = '0;
          next_valid    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ratio.multiple <= '0;
      ratio.valid    <= 1'b0;
    end else if (clock_enable) begin
      ratio.multiple <= next_multiple;
      ratio.valid    <= next_valid;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_family_256_top: assert property (@(posedge ref_clk) disable iff (reset)
    (clock_enable && ratio.family == 2'h0 && ratio.code == 4'h9)
      |=> (ratio.multiple == 11'h600 && ratio.valid))
    else $error("256 family code 9 not 1536");

  a_family_272_top: assert property (@(posedge ref_clk) disable iff (reset)
    (clock_enable && ratio.family == 2'h1 && ratio.code == 4'h8)
      |=> (ratio.multiple == 11'h5D8 && ratio.valid))
    else $error("272 family code 8 not 1496");

  a_family_250_pair: assert property (@(posedge ref_clk) disable iff (reset)
    (clock_enable && ratio.family == 2'h2 && ratio.code[3:1] == 3'h0)
      |=> (ratio.multiple == 11'h07D && ratio.valid))
    else $error("250 family codes 0 and 1 not 125");

  a_reserved_code: assert property (@(posedge ref_clk) disable iff (reset)
    (clock_enable && (ratio.code >= 4'hA || ratio.family == 2'h3))
      |=> !ratio.valid)
    else $error("reserved ratio code flagged valid");

  c_family_250: cover property (@(posedge ref_clk) disable iff (reset)
    ratio.valid && ratio.multiple == 11'h5DC);

endmodule

`default_nettype wire

//--- design/pecc_top.sv
`timescale 1ns/1ns
`default_nettype none

module pecc_top (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          clock_enable,
  input  wire logic [pecc_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [pecc_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [pecc_pkg::BE_W-1:0]     avs_byteenable,
  output var  logic [pecc_pkg::DATA_W-1:0]   avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          master_clock_tick,
  input  wire logic                          loop_clock_tick,
  output var  logic                          system_clock_tick,
  output var  logic                          left_line_out_enable,
  output var  logic                          right_line_out_enable,
  output var  logic                          left_speaker_mixer_enable,
  output var  logic                          right_speaker_mixer_enable,
  output var  logic                          left_speaker_driver_enable,
  output var  logic                          right_speaker_driver_enable,
  output var  logic                          left_dac_power,
  output var  logic                          right_dac_power,
  output var  logic                          left_adc_power,
  output var  logic                          right_adc_power,
  output var  logic                          master_clock_halve,
  output var  logic                          system_clock_source,
  output var  logic [3:0]                    system_clock_ratio,
  output var  logic [1:0]                    clock_family_select,
  output logic [pecc_pkg::RATIO_W-1:0]       ratio_multiple,
  output logic                               ratio_valid
);

  pecc_pkg::pecc_bus_state_type state;
  pecc_pkg::pecc_bus_state_type next_state;
  logic                         request;
  logic                         write_accept;
  logic                         low_lane;
  logic                         high_lane;
  logic [pecc_pkg::DATA_W-1:0]  next_readdata;
  logic [pecc_pkg::REG_W-1:0]   wdata;
  logic                         halve_phase;
  logic                         next_system_tick;

  pecc_ratio_if ratio_bus ();

  // ----------------------------------------------------------------
  // Avalon slave handshake
  // ----------------------------------------------------------------
  assign request         = avs_read | avs_write;
  assign avs_waitrequest = request & (state != pecc_pkg::BUS_ANSWER);
  assign write_accept    = clock_enable & avs_write & (state == pecc_pkg::BUS_ANSWER);
  assign low_lane        = avs_byteenable[0];
  assign high_lane       = avs_byteenable[1];
  assign wdata           = avs_writedata[pecc_pkg::REG_W-1:0];

  always_comb begin
    next_state = state;
    unique case (state)
      pecc_pkg::BUS_IDLE: begin
        if (request) begin
          next_state = pecc_pkg::BUS_ANSWER;
        end
      end
      pecc_pkg::BUS_ANSWER: begin
        next_state = pecc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= pecc_pkg::BUS_IDLE;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    next_readdata = '0;
    unique case (avs_address)
      pecc_pkg::ADDR_LINE_OUT: begin
        next_readdata[pecc_pkg::LEFT_BIT]  = left_line_out_enable;
        next_readdata[pecc_pkg::RIGHT_BIT] = right_line_out_enable;
      end
      pecc_pkg::ADDR_SPK_MIXER: begin
        next_readdata[pecc_pkg::LEFT_BIT]  = left_speaker_mixer_enable;
        next_readdata[pecc_pkg::RIGHT_BIT] = right_speaker_mixer_enable;
      end
      pecc_pkg::ADDR_SPK_OUTPUT: begin
        next_readdata[pecc_pkg::LEFT_BIT]  = left_speaker_driver_enable;
        next_readdata[pecc_pkg::RIGHT_BIT] = right_speaker_driver_enable;
      end
      pecc_pkg::ADDR_CONVERTER: begin
        next_readdata[pecc_pkg::DAC_LEFT_BIT]  = left_dac_power;
        next_readdata[pecc_pkg::DAC_RIGHT_BIT] = right_dac_power;
        next_readdata[pecc_pkg::ADC_LEFT_BIT]  = left_adc_power;
        next_readdata[pecc_pkg::ADC_RIGHT_BIT] = right_adc_power;
      end
      pecc_pkg::ADDR_MCLK_DIV: begin
        next_readdata[pecc_pkg::HALVE_BIT] = master_clock_halve;
      end
      pecc_pkg::ADDR_SYS_RATE: begin
        next_readdata[pecc_pkg::SOURCE_BIT] = system_clock_source;
        next_readdata[pecc_pkg::RATIO_MSB:pecc_pkg::RATIO_LSB] = system_clock_ratio;
        next_readdata[pecc_pkg::FAMILY_MSB:pecc_pkg::FAMILY_LSB] = clock_family_select;
      end
      default: begin
        next_readdata = '0;
      end
    endcase
  end

  // Data captured on the request edge, shown on the answer cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (clock_enable && avs_read && state == pecc_pkg::BUS_IDLE) begin
      avs_readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Power enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      left_line_out_enable  <= pecc_pkg::ENABLE_RESET;
      right_line_out_enable <= pecc_pkg::ENABLE_RESET;
    end else if (write_accept && low_lane && avs_address == pecc_pkg::ADDR_LINE_OUT) begin
      left_line_out_enable  <= wdata[pecc_pkg::LEFT_BIT];
      right_line_out_enable <= wdata[pecc_pkg::RIGHT_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      left_speaker_mixer_enable  <= pecc_pkg::ENABLE_RESET;
      right_speaker_mixer_enable <= pecc_pkg::ENABLE_RESET;
    end else if (write_accept && low_lane && avs_address == pecc_pkg::ADDR_SPK_MIXER) begin
      left_speaker_mixer_enable  <= wdata[pecc_pkg::LEFT_BIT];
      right_speaker_mixer_enable <= wdata[pecc_pkg::RIGHT_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      left_speaker_driver_enable  <= pecc_pkg::ENABLE_RESET;
      right_speaker_driver_enable <= pecc_pkg::ENABLE_RESET;
    end else if (write_accept && low_lane && avs_address == pecc_pkg::ADDR_SPK_OUTPUT) begin
      left_speaker_driver_enable  <= wdata[pecc_pkg::LEFT_BIT];
      right_speaker_driver_enable <= wdata[pecc_pkg::RIGHT_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      left_dac_power  <= pecc_pkg::ENABLE_RESET;
      right_dac_power <= pecc_pkg::ENABLE_RESET;
      left_adc_power  <= pecc_pkg::ENABLE_RESET;
      right_adc_power <= pecc_pkg::ENABLE_RESET;
    end else if (write_accept && low_lane && avs_address == pecc_pkg::ADDR_CONVERTER) begin
      left_dac_power  <= wdata[pecc_pkg::DAC_LEFT_BIT];
      right_dac_power <= wdata[pecc_pkg::DAC_RIGHT_BIT];
      left_adc_power  <= wdata[pecc_pkg::ADC_LEFT_BIT];
      right_adc_power <= wdata[pecc_pkg::ADC_RIGHT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Clock configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      master_clock_halve <= pecc_pkg::HALVE_RESET;
    end else if (write_accept && low_lane && avs_address == pecc_pkg::ADDR_MCLK_DIV) begin
      master_clock_halve <= wdata[pecc_pkg::HALVE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      system_clock_source <= pecc_pkg::SOURCE_RESET;
      system_clock_ratio  <= pecc_pkg::RATIO_RESET;
      clock_family_select <= pecc_pkg::FAMILY_RESET;
    end else if (write_accept && high_lane && avs_address == pecc_pkg::ADDR_SYS_RATE) begin
      system_clock_source <= wdata[pecc_pkg::SOURCE_BIT];
      system_clock_ratio  <= wdata[pecc_pkg::RATIO_MSB:pecc_pkg::RATIO_LSB];
      clock_family_select <= wdata[pecc_pkg::FAMILY_MSB:pecc_pkg::FAMILY_LSB];
    end
  end

  // ----------------------------------------------------------------
  // System clock derivation
  // ----------------------------------------------------------------
  // Halving keeps every second master tick
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      halve_phase <= 1'b0;
    end else if (clock_enable) begin
      if (!master_clock_halve) begin
        halve_phase <= 1'b0;
      end else if (master_clock_tick) begin
        halve_phase <= ~halve_phase;
      end
    end
  end

  always_comb begin
    if (system_clock_source) begin
      next_system_tick = loop_clock_tick;
    end else if (master_clock_halve) begin
      next_system_tick = master_clock_tick & halve_phase;
    end else begin
      next_system_tick = master_clock_tick;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      system_clock_tick <= 1'b0;
    end else if (clock_enable) begin
      system_clock_tick <= next_system_tick;
    end
  end

  // ----------------------------------------------------------------
  // Ratio decoding
  // ----------------------------------------------------------------
  assign ratio_bus.family = clock_family_select;
  assign ratio_bus.code   = system_clock_ratio;
  assign ratio_multiple   = ratio_bus.multiple;
  assign ratio_valid      = ratio_bus.valid;

  pecc_ratio_decode u_ratio_decode (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .clock_enable (clock_enable),
    .ratio        (ratio_bus.decoder)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (reset);

  a_line_out_write: assert property (
    (write_accept && low_lane && avs_address == 8'h3C)
      |=> (left_line_out_enable == $past(avs_writedata[1])
           && right_line_out_enable == $past(avs_writedata[0])))
    else $error("line output enables not written");

  a_mixer_write: assert property (
    (write_accept && low_lane && avs_address == 8'h40)
      |=> (left_speaker_mixer_enable == $past(avs_writedata[1])
           && right_speaker_mixer_enable == $past(avs_writedata[0])))
    else $error("speaker mixer enables not written");

  a_driver_write: assert property (
    (write_accept && low_lane && avs_address == 8'h44)
      |=> (left_speaker_driver_enable == $past(avs_writedata[1])
           && right_speaker_driver_enable == $past(avs_writedata[0])))
    else $error("speaker driver enables not written");

  a_converter_write: assert property (
    (write_accept && low_lane && avs_address == 8'h48)
      |=> ({left_dac_power, right_dac_power, left_adc_power, right_adc_power}
           == $past(avs_writedata[3:0])))
    else $error("converter enables not written");

  a_reset_values: assert property (
    disable iff (1'b0)
    ($past(reset) && !reset) |-> (!left_line_out_enable && !right_line_out_enable
      && !left_speaker_mixer_enable && !right_speaker_mixer_enable
      && !left_speaker_driver_enable && !right_speaker_driver_enable
      && !left_dac_power && !right_dac_power && !left_adc_power && !right_adc_power
      && !master_clock_halve && !system_clock_source && system_clock_ratio == 4'h3))
    else $error("control state wrong after reset");

  a_loop_source: assert property (
    (clock_enable && system_clock_source) |=> (system_clock_tick == $past(loop_clock_tick)))
    else $error("loop clock source not followed");

  a_master_halved: assert property (
    (clock_enable && !system_clock_source && master_clock_halve && master_clock_tick)
      ##1 (clock_enable && !system_clock_source && master_clock_halve && master_clock_tick)
      |=> !system_clock_tick || !$past(system_clock_tick))
    else $error("halved master clock passes two ticks in a row");

  a_ratio_readback: assert property (
    (clock_enable && avs_read && state == pecc_pkg::BUS_IDLE && avs_address == 8'h54)
      |=> (avs_readdata[13:10] == $past(system_clock_ratio) && avs_readdata[7:0] == 8'h00))
    else $error("ratio field readback wrong");

  a_answer_timing: assert property (
    (clock_enable && request && state == pecc_pkg::BUS_IDLE) ##1 (clock_enable && request)
      |-> !avs_waitrequest)
    else $error("slave did not answer in one cycle");

  a_frozen_tick: assert property (
    !clock_enable |=> ($stable(system_clock_tick) && $stable(halve_phase)))
    else $error("system clock tick moved while frozen");

  a_master_direct: assert property (
    (clock_enable && !system_clock_source && !master_clock_halve)
      |=> (system_clock_tick == $past(master_clock_tick)))
    else $error("master clock not followed");

  a_rate_write: assert property (
    (write_accept && high_lane && avs_address == pecc_pkg::ADDR_SYS_RATE)
      |=> (system_clock_ratio == $past(avs_writedata[13:10])
           && system_clock_source == $past(avs_writedata[15])))
    else $error("system clock rate fields not written");

  a_halve_write: assert property (
    (write_accept && low_lane && avs_address == pecc_pkg::ADDR_MCLK_DIV)
      |=> (master_clock_halve == $past(avs_writedata[0])))
    else $error("halve bit not written");

  a_lane_guard: assert property (
    (write_accept && !low_lane && avs_address == pecc_pkg::ADDR_LINE_OUT)
      |=> $stable({left_line_out_enable, right_line_out_enable}))
    else $error("line output changed with lane off");

  c_loop_source: cover property (system_clock_source && system_clock_tick);
  c_halve_on: cover property (master_clock_halve && system_clock_tick);
  c_write_rate: cover property (write_accept && avs_address == 8'h54);
  c_read_power: cover property (avs_read && !avs_waitrequest && avs_address == 8'h48);

endmodule

`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
    logic [15:0] back;
    logic [17:0] outs;
  } pecc_row_type;

  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clock_enable = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        master_clock_tick = 1'b0;
  logic        loop_clock_tick = 1'b0;
  logic        system_clock_tick, ratio_valid;
  logic        lo_l, lo_r, mx_l, mx_r, sp_l, sp_r, dac_l, dac_r, adc_l, adc_r, halve, source;
  logic [3:0]  ratio;
  logic [1:0]  family;
  logic [10:0] ratio_multiple;
  logic [17:0] outs;
  logic [31:0] rd;
  int          mismatches = 0;
  int          total_checks = 0;
  logic [10:0] mult [0:29] = '{11'h040, 11'h080, 11'h0C0, 11'h100, 11'h180, 11'h200, 11'h300,
    11'h400, 11'h580, 11'h600, 11'h044, 11'h088, 11'h0CC, 11'h110, 11'h198, 11'h220, 11'h330,
    11'h440, 11'h5D8, 11'h660, 11'h07D, 11'h07D, 11'h0FA, 11'h0FA, 11'h177, 11'h1F4, 11'h2EE,
    11'h3E8, 11'h3E8, 11'h5DC};
  pecc_row_type rows [0:7] = '{
    '{8'h3C, 16'h0002, 16'h0002, 18'h2000C}, '{8'h3C, 16'hFFFD, 16'h0001, 18'h1000C},
    '{8'h40, 16'h0003, 16'h0003, 18'h1C00C}, '{8'h44, 16'h0001, 16'h0001, 18'h1D00C},
    '{8'h48, 16'h000A, 16'h000A, 18'h1DA0C}, '{8'h48, 16'h0005, 16'h0005, 18'h1D50C},
    '{8'h50, 16'h0001, 16'h0001, 18'h1D58C}, '{8'h54, 16'h950F, 16'h9500, 18'h1D5D5}};

  assign outs = {lo_l, lo_r, mx_l, mx_r, sp_l, sp_r, dac_l, dac_r, adc_l, adc_r, halve, source,
                 ratio, family};

  always #10 ref_clk = ~ref_clk;

  pecc_top pecc_top_inst (.ref_clk(ref_clk), .reset(reset), .clock_enable(clock_enable),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .master_clock_tick(master_clock_tick), .loop_clock_tick(loop_clock_tick),
    .system_clock_tick(system_clock_tick), .left_line_out_enable(lo_l),
    .right_line_out_enable(lo_r), .left_speaker_mixer_enable(mx_l),
    .right_speaker_mixer_enable(mx_r), .left_speaker_driver_enable(sp_l),
    .right_speaker_driver_enable(sp_r), .left_dac_power(dac_l), .right_dac_power(dac_r),
    .left_adc_power(adc_l), .right_adc_power(adc_r), .master_clock_halve(halve),
    .system_clock_source(source), .system_clock_ratio(ratio), .clock_family_select(family),
    .ratio_multiple(ratio_multiple), .ratio_valid(ratio_valid));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waits for the answer cycle; read data stand in it
  task automatic bus_access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n < 40) begin
      rd = avs_readdata;
    end else begin
      mismatches++;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge ref_clk);
    if (n == 40) begin
      complete_run();
    end
  endtask

  task automatic pulse(input logic m, input logic l, input logic exp);
    @(posedge ref_clk);
    master_clock_tick <= m;
    loop_clock_tick <= l;
    @(posedge ref_clk);
    master_clock_tick <= 1'b0;
    loop_clock_tick <= 1'b0;
    @(negedge ref_clk);
    check("system_clock_tick", system_clock_tick, exp);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      bus_access(1'b0, (i == 6) ? 8'h54 : 8'h3C + 8'(4 * i), 32'h0, 4'hF);
      check("reset value", rd, (i == 6) ? 32'h00000C00 : 32'h0);
    end
    check("reset outputs", 32'(outs), 32'h0000C);
    foreach (rows[i]) begin
      bus_access(1'b1, rows[i].addr, 32'(rows[i].data), 4'hF);
      check("outputs", 32'(outs), 32'(rows[i].outs));
      bus_access(1'b0, rows[i].addr, 32'h0, 4'hF);
      check("readback", rd, 32'(rows[i].back));
    end
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 10; c++) begin // Legal codes only
        bus_access(1'b1, 8'h54, {18'h0, 4'(c), 2'(f), 8'h00}, 4'hF);
        @(negedge ref_clk);
        check("ratio_multiple", 32'(ratio_multiple), 32'(mult[f * 10 + c]));
        check("ratio_valid", 32'(ratio_valid), 32'h1);
      end
    end
    bus_access(1'b1, 8'h54, 32'h00000C00, 4'hD);
    check("lane off rate", 32'(ratio), 32'h9);
    bus_access(1'b1, 8'h3C, 32'h00000002, 4'hE);
    check("lane off line", 32'(outs[17:16]), 32'h1);
    bus_access(1'b1, 8'h4C, 32'h0000FFFF, 4'hF);
    check("unmapped write", 32'(outs), 32'h1D5A6);
    bus_access(1'b0, 8'h3D, 32'h0, 4'hF);
    check("misaligned read", rd, 32'h0);
    bus_access(1'b1, 8'h54, 32'h00000F00, 4'hF);
    @(negedge ref_clk);
    check("reserved family valid", 32'(ratio_valid), 32'h0);
    check("reserved family multiple", 32'(ratio_multiple), 32'h0);
    bus_access(1'b1, 8'h54, 32'h00000C00, 4'hF);
    bus_access(1'b1, 8'h50, 32'h00000000, 4'hF);
    pulse(1'b1, 1'b0, 1'b1);
    pulse(1'b0, 1'b1, 1'b0);
    bus_access(1'b1, 8'h50, 32'h00000001, 4'hF);
    pulse(1'b1, 1'b0, 1'b0);
    pulse(1'b1, 1'b0, 1'b1);
    bus_access(1'b1, 8'h54, 32'h00008C00, 4'hF);
    pulse(1'b0, 1'b1, 1'b1);
    pulse(1'b1, 1'b0, 1'b0);
    @(posedge ref_clk);
    clock_enable <= 1'b0;
    pulse(1'b0, 1'b1, 1'b0);
    @(posedge ref_clk);
    clock_enable <= 1'b1;
    bus_access(1'b1, 8'h54, 32'h00000C00, 4'hF);
    // Two master ticks in a row, halved
    @(posedge ref_clk);
    master_clock_tick <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    check("halved first tick", 32'(system_clock_tick), 32'h1);
    @(posedge ref_clk);
    master_clock_tick <= 1'b0;
    @(negedge ref_clk);
    check("halved second tick", 32'(system_clock_tick), 32'h0);
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check("second reset", 32'(outs), 32'h0000C);
    complete_run();
  end
endmodule

`default_nettype wire
